// >>> hdl/ssc_regs.vh
// Constants for the solo select controller: register map, field positions,
// reset values and debounce timing.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef SSC_REGS_VH
`define SSC_REGS_VH

// Clock rate in kHz
`define SSC_CLK_KHZ        125000
// Switch settle time in milliseconds
`define SSC_DEB_MS         5
// Debounce count derived from the settle time
`define SSC_DEB_CYCLES     (`SSC_DEB_MS * `SSC_CLK_KHZ)

// Register byte offsets
`define SSC_ADDR_W         8
`define SSC_OFS_CTRL       8'h00
`define SSC_OFS_STATUS     8'h04
`define SSC_OFS_IN_SOLO    8'h08
`define SSC_OFS_OUT_MEM    8'h0c
`define SSC_OFS_OUT_LIT    8'h10
`define SSC_OFS_CMD        8'h14

// Control register fields
`define SSC_CTRL_LAST      0
`define SSC_CTRL_PRIO      1
`define SSC_CTRL_POST      2
`define SSC_CTRL_W         3
`define SSC_CTRL_RST       3'h0

// Status register fields
`define SSC_STAT_IN        0
`define SSC_STAT_OUT       1
`define SSC_STAT_CLR       2
`define SSC_STAT_POST      3

// Command register: write 1 to act as a clear press
`define SSC_CMD_CLEAR      0

// AXI response codes
`define SSC_RESP_OKAY      2'h0
`define SSC_RESP_DECERR    2'h3

`endif

// >>> hdl/ssc_debounce.v
// Switch conditioner for the solo select controller: synchroniser,
// debounce counter and press detector for a vector of switches.
// Assumes switches read high while pressed and are asynchronous to ref_clk.
module ssc_debounce #(
    parameter WIDTH  = 15,
    parameter CNT_W  = 20,
    parameter SETTLE = 625000
) (
    input  wire             ref_clk,  // System clock
    input  wire             sys_rst,  // Synchronous reset, active high
    input  wire [WIDTH-1:0] sw_raw,   // Raw switch levels
    output reg  [WIDTH-1:0] press_q   // One-cycle press events
);

    localparam integer     SETTLE_I  = SETTLE - 1;
    localparam [CNT_W-1:0] SETTLE_M1 = SETTLE_I[CNT_W-1:0];

    reg [WIDTH-1:0] sync1_q;
    reg [WIDTH-1:0] sync2_q;
    reg [WIDTH-1:0] stable_q;

    // Two flops before anything looks at the pins
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            sync1_q <= {WIDTH{1'b0}};
            sync2_q <= {WIDTH{1'b0}};
        end else begin
            sync1_q <= sw_raw;
            sync2_q <= sync1_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : gen_bit
            reg [CNT_W-1:0] cnt_q;
            // Level must hold unchanged for the whole settle time
            always @(posedge ref_clk) begin
                if (sys_rst) begin
                    cnt_q       <= {CNT_W{1'b0}};
                    stable_q[g] <= 1'b0;
                    press_q[g]  <= 1'b0;
                end else begin
                    press_q[g] <= 1'b0;
                    if (sync2_q[g] == stable_q[g]) begin
                        cnt_q <= {CNT_W{1'b0}};
                    end else if (cnt_q == SETTLE_M1) begin
                        cnt_q       <= {CNT_W{1'b0}};
                        stable_q[g] <= sync2_q[g];
                        press_q[g]  <= sync2_q[g];
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
            end
        end
    endgenerate

endmodule

// >>> hdl/ssc_solo_ctrl.v
// Solo select controller: keeps the set of active solos of a mixing
// console and drives the solo lamps, the clear lamp and the tap point.
// Assumes panel switches are raw, high while pressed, and software
// reaches the mode settings over AXI4-Lite on the same clock.
//
// Functional notes
// - Additive mode toggles a source in or out of the solo set on each press.
// - Last-pressed mode keeps only the source pressed most recently.
// - Last-pressed mode empties the set when the active source is pressed again.
// - Pressing any lit solo switch cancels that solo in every mode.
// - With input priority an input solo hides output solos; additive mode remembers them.
// - With input priority remembered outputs return once no input solo is left.
// - Channels, common returns and local returns all count as inputs.
// - Without input priority inputs and outputs may be soloed together.
// - Green lamp shows any input solo, red lamp shows any output solo.
// - The clear switch is lit while any solo anywhere is active.
// - Without input priority one clear press cancels every solo.
// - With input priority clear first cancels inputs, then the returned outputs.
// - A global tap setting picks pre-level or after-level listening.
// - Each solo switch has its own yellow lamp lit while its solo shows.
// - Bus A, bus B and matrix solos count as outputs.
`include "ssc_regs.vh"

module ssc_solo_ctrl #(
    parameter N_IN       = 8,                // Input-class sources
    parameter N_OUT      = 6,                // Output-class sources
    parameter DEB_CYCLES = `SSC_DEB_CYCLES,  // Debounce settle count
    parameter DEB_W      = 20                // Debounce counter width
) (
    input  wire                   ref_clk,            // System clock
    input  wire                   sys_rst,            // Sync reset, high
    // Panel switches
    input  wire [N_IN-1:0]        in_solo_sw,         // Input solo switches
    input  wire [N_OUT-1:0]       out_solo_sw,        // Output solo switches
    input  wire                   clear_sw,           // Clear switch
    // Panel lamps
    output reg  [N_IN-1:0]        in_solo_led_q,      // Yellow input lamps
    output reg  [N_OUT-1:0]       out_solo_led_q,     // Yellow output lamps
    output reg                    in_active_led_q,    // Green input lamp
    output reg                    out_active_led_q,   // Red output lamp
    output reg                    clear_lamp_q,       // Clear switch lamp
    output reg                    pre_level_listen_q, // Pre-fader tap
    output reg                    after_level_listen_q, // Post-fader tap
    // AXI4-Lite slave
    input  wire [`SSC_ADDR_W-1:0] s_axi_awaddr,       // Write address
    input  wire                   s_axi_awvalid,      // Write address valid
    output reg                    s_axi_awready,      // Write address ready
    input  wire [31:0]            s_axi_wdata,        // Write data
    input  wire [3:0]             s_axi_wstrb,        // Write strobes
    input  wire                   s_axi_wvalid,       // Write data valid
    output reg                    s_axi_wready,       // Write data ready
    output reg  [1:0]             s_axi_bresp,        // Write response
    output reg                    s_axi_bvalid,       // Write response valid
    input  wire                   s_axi_bready,       // Response ready
    input  wire [`SSC_ADDR_W-1:0] s_axi_araddr,       // Read address
    input  wire                   s_axi_arvalid,      // Read address valid
    output reg                    s_axi_arready,      // Read address ready
    output reg  [31:0]            s_axi_rdata,        // Read data
    output reg  [1:0]             s_axi_rresp,        // Read response
    output reg                    s_axi_rvalid,       // Read data valid
    input  wire                   s_axi_rready        // Read data ready
);

    localparam N_SRC = N_IN + N_OUT;
    localparam N_SW  = N_SRC + 1;

    // Output solos shown on the bus: hidden while inputs hold priority
    function [N_OUT-1:0] out_shown;
        input [N_OUT-1:0] mem;
        input             prio;
        input             in_any;
        begin
            out_shown = (prio && in_any) ? {N_OUT{1'b0}} : mem;
        end
    endfunction

    // Address is one of the mapped word offsets
    function mapped;
        input [`SSC_ADDR_W-1:0] a;
        begin
            mapped = (a == `SSC_OFS_CTRL)    || (a == `SSC_OFS_STATUS)  ||
                     (a == `SSC_OFS_IN_SOLO) || (a == `SSC_OFS_OUT_MEM) ||
                     (a == `SSC_OFS_OUT_LIT) || (a == `SSC_OFS_CMD);
        end
    endfunction

    // Switch conditioning
    wire [N_SW-1:0]  press;
    wire [N_IN-1:0]  in_ev;
    wire [N_OUT-1:0] out_ev;
    wire             clr_panel;

    ssc_debounce #(
        .WIDTH  (N_SW),
        .CNT_W  (DEB_W),
        .SETTLE (DEB_CYCLES)
    ) u_deb (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .sw_raw  ({clear_sw, out_solo_sw, in_solo_sw}),
        .press_q (press)
    );

    // Input class covers channels and both return kinds, outputs the buses
    assign in_ev     = press[N_IN-1:0];
    assign out_ev    = press[N_SRC-1:N_IN];
    assign clr_panel = press[N_SRC];

    // Solo state and mode settings
    reg [N_IN-1:0]          in_act_q;
    reg [N_IN-1:0]          in_act_d;
    reg [N_OUT-1:0]         out_mem_q;
    reg [N_OUT-1:0]         out_mem_d;
    reg [`SSC_CTRL_W-1:0]   ctrl_q;
    reg                     sw_clr_q;

    // Bus state
    reg                     aw_full_q;
    reg                     w_full_q;
    reg [`SSC_ADDR_W-1:0]   awaddr_q;
    reg [31:0]              wdata_q;
    reg                     wstrb0_q;

    wire excl    = ctrl_q[`SSC_CTRL_LAST];
    wire prio    = ctrl_q[`SSC_CTRL_PRIO];
    wire post    = ctrl_q[`SSC_CTRL_POST];
    wire in_any  = |in_act_q;
    wire clr_ev  = clr_panel | sw_clr_q;

    wire [N_OUT-1:0] out_lit  = out_shown(out_mem_q, prio, in_any);
    wire [N_SRC-1:0] ev_all   = {out_ev, in_ev};
    wire [N_SRC-1:0] lit_all  = {out_lit, in_act_q};
    // Lowest-numbered press wins when several land in one cycle
    wire [N_SRC-1:0] pick     = ev_all & (~ev_all + {{(N_SRC-1){1'b0}}, 1'b1});

    wire [N_OUT-1:0] out_lit_d = out_shown(out_mem_d, prio, |in_act_d);

    // Next solo set; a clear press takes precedence over solo presses
    always @* begin
        in_act_d  = in_act_q;
        out_mem_d = out_mem_q;
        if (clr_ev) begin
            if (prio && in_any) begin
                // Inputs go first, remembered outputs come back
                in_act_d = {N_IN{1'b0}};
            end else begin
                in_act_d  = {N_IN{1'b0}};
                out_mem_d = {N_OUT{1'b0}};
            end
        end else if (excl) begin
            if (|(pick & lit_all)) begin
                // Same lit source again empties the set
                in_act_d  = {N_IN{1'b0}};
                out_mem_d = {N_OUT{1'b0}};
            end else if (|pick) begin
                in_act_d  = pick[N_IN-1:0];
                out_mem_d = pick[N_SRC-1:N_IN];
            end
        end else begin
            // Additive: a press flips membership, lit ones drop out
            in_act_d = in_act_q ^ in_ev;
            // Hidden outputs keep their memory; the press edits it
            out_mem_d = out_mem_q ^ out_ev;
        end
    end

    // Solo state registers
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            in_act_q  <= {N_IN{1'b0}};
            out_mem_q <= {N_OUT{1'b0}};
        end else begin
            in_act_q  <= in_act_d;
            // Output memory is wiped by an input solo only in last-pressed mode
            out_mem_q <= out_mem_d;
        end
    end

    // Lamps follow the next state so they change with the set itself
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            in_solo_led_q        <= {N_IN{1'b0}};
            out_solo_led_q       <= {N_OUT{1'b0}};
            in_active_led_q      <= 1'b0;
            out_active_led_q     <= 1'b0;
            clear_lamp_q         <= 1'b0;
            pre_level_listen_q   <= 1'b0;
            after_level_listen_q <= 1'b0;
        end else begin
            in_solo_led_q        <= in_act_d;
            out_solo_led_q       <= out_lit_d;
            in_active_led_q      <= |in_act_d;
            out_active_led_q     <= |out_lit_d;
            clear_lamp_q         <= (|in_act_d) | (|out_lit_d);
            pre_level_listen_q   <= ~post;
            after_level_listen_q <= post;
        end
    end

    // Write path: address and data are taken in either order,
    // and both readies stay low until the response is accepted
    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs  = s_axi_wvalid & s_axi_wready;
    wire do_wr = aw_full_q & w_full_q & ~s_axi_bvalid;

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            aw_full_q     <= 1'b0;
            w_full_q      <= 1'b0;
            awaddr_q      <= {`SSC_ADDR_W{1'b0}};
            wdata_q       <= 32'h0000_0000;
            wstrb0_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SSC_RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_full_q     <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_full_q && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (w_hs) begin
                w_full_q     <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb0_q     <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end else if (!w_full_q && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (do_wr) begin
                aw_full_q    <= 1'b0;
                w_full_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(awaddr_q) ? `SSC_RESP_OKAY
                                                 : `SSC_RESP_DECERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register writes; all writable fields live in byte lane 0
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_q   <= `SSC_CTRL_RST;
            sw_clr_q <= 1'b0;
        end else begin
            sw_clr_q <= 1'b0;
            if (do_wr && wstrb0_q) begin
                if (awaddr_q == `SSC_OFS_CTRL) begin
                    ctrl_q <= wdata_q[`SSC_CTRL_W-1:0];
                end else if (awaddr_q == `SSC_OFS_CMD) begin
                    sw_clr_q <= wdata_q[`SSC_CMD_CLEAR];
                end
            end
        end
    end

    // Read data selection
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0000_0000;
        if (s_axi_araddr == `SSC_OFS_CTRL) begin
            rd_mux[`SSC_CTRL_W-1:0] = ctrl_q;
        end else if (s_axi_araddr == `SSC_OFS_STATUS) begin
            rd_mux[`SSC_STAT_IN]   = in_active_led_q;
            rd_mux[`SSC_STAT_OUT]  = out_active_led_q;
            rd_mux[`SSC_STAT_CLR]  = clear_lamp_q;
            rd_mux[`SSC_STAT_POST] = after_level_listen_q;
        end else if (s_axi_araddr == `SSC_OFS_IN_SOLO) begin
            rd_mux[N_IN-1:0] = in_act_q;
        end else if (s_axi_araddr == `SSC_OFS_OUT_MEM) begin
            rd_mux[N_OUT-1:0] = out_mem_q;
        end else if (s_axi_araddr == `SSC_OFS_OUT_LIT) begin
            rd_mux[N_OUT-1:0] = out_lit;
        end
    end

    // Read path: one read at a time, answered the cycle after the address
    wire ar_hs = s_axi_arvalid & s_axi_arready;

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `SSC_RESP_OKAY;
        end else begin
            if (ar_hs) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mux;
                s_axi_rresp   <= mapped(s_axi_araddr) ? `SSC_RESP_OKAY
                                                      : `SSC_RESP_DECERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// >>> sim/ssc_solo_chk.sv
// Port checker for the solo select controller.
// Assumes it is bound to ssc_solo_ctrl and sees only its ports.
module ssc_solo_chk #(
    parameter N_IN  = 8,
    parameter N_OUT = 6
) (
    input wire logic             ref_clk,              // Clock
    input wire logic             sys_rst,              // Reset
    input wire logic [N_IN-1:0]  in_solo_led_q,        // Input lamps
    input wire logic [N_OUT-1:0] out_solo_led_q,       // Output lamps
    input wire logic             in_active_led_q,      // Green
    input wire logic             out_active_led_q,     // Red
    input wire logic             clear_lamp_q,         // Clear lamp
    input wire logic             pre_level_listen_q,   // Pre tap
    input wire logic             after_level_listen_q, // Post tap
    input wire logic             s_axi_awvalid,        // AW valid
    input wire logic             s_axi_awready,        // AW ready
    input wire logic             s_axi_wvalid,         // W valid
    input wire logic             s_axi_wready,         // W ready
    input wire logic [1:0]       s_axi_bresp,          // B resp
    input wire logic             s_axi_bvalid,         // B valid
    input wire logic             s_axi_bready,         // B ready
    input wire logic             s_axi_arvalid,        // AR valid
    input wire logic             s_axi_arready,        // AR ready
    input wire logic [31:0]      s_axi_rdata,          // R data
    input wire logic             s_axi_rvalid,         // R valid
    input wire logic             s_axi_rready          // R ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Both write channels taken at one edge
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // Tap outputs settle two edges after release, then stay opposite
    a_tap_onehot: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |->
        pre_level_listen_q != after_level_listen_q) else $error("tap outputs not exclusive");
    a_green_any: assert property (in_active_led_q == (|in_solo_led_q))
        else $error("green lamp wrong");
    a_red_any: assert property (out_active_led_q == (|out_solo_led_q))
        else $error("red lamp wrong");
    a_clear_lit: assert property (clear_lamp_q == (in_active_led_q || out_active_led_q))
        else $error("clear lamp wrong");
    a_wr_answer: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
        else $error("write answer late");
    a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule

// >>> sim/ssc_panel.sv
// Front panel model: momentary switches pressed on command.
// Assumes index 0-7 inputs, 8-13 outputs, 14 the clear switch.
module ssc_panel (
    input  wire logic       ref_clk,     // Clock
    input  wire logic       go,          // Start one press
    input  wire logic [3:0] idx,         // Switch to press
    input  wire logic       chatter,     // Bounce only, too short
    output wire logic [7:0] in_solo_sw,  // Input switches
    output wire logic [5:0] out_solo_sw, // Output switches
    output wire logic       clear_sw     // Clear switch
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [14:0] lvl_q = 15'h0;
    int          left_q = 0;
    // Held press is long, chatter shorter than the bench settle count of 4
    always @(posedge ref_clk) begin
        if (go) begin
            lvl_q <= 15'h1 << idx;
            left_q <= chatter ? 2 : 12;
        end else if (left_q > 0) begin
            left_q <= left_q - 1;
        end else begin
            lvl_q <= 15'h0;
        end
    end
    assign in_solo_sw = lvl_q[7:0];
    assign out_solo_sw = lvl_q[13:8];
    assign clear_sw = lvl_q[14];
endmodule

// >>> sim/solo_select_controller_bench.sv
// Self-checking bench for the solo controller with a solo-set model.
// Assumes ssc_regs.vh offsets and a short debounce count of 4.
`include "ssc_regs.vh"
module solo_select_controller_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, sys_rst, go, chatter;
    logic [3:0] idx;
    wire [7:0] in_solo_sw, in_led;
    wire [5:0] out_solo_sw, out_led;
    wire clear_sw, in_act, out_act, clr_lamp, pre_t, post_t;
    logic [7:0] s_axi_awaddr, s_axi_araddr, lfsr_q;
    logic [31:0] s_axi_wdata, rd;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    int num_errors, total_checks, cycles, in_m, mem_m, mode_m, m, n;

    ssc_panel panel (.ref_clk(ref_clk), .go(go), .idx(idx), .chatter(chatter), .in_solo_sw(in_solo_sw),
        .out_solo_sw(out_solo_sw), .clear_sw(clear_sw));
    ssc_solo_ctrl #(.N_IN(8), .N_OUT(6), .DEB_CYCLES(4), .DEB_W(20)) dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .in_solo_sw(in_solo_sw), .out_solo_sw(out_solo_sw),
        .clear_sw(clear_sw), .in_solo_led_q(in_led), .out_solo_led_q(out_led), .in_active_led_q(in_act),
        .out_active_led_q(out_act), .clear_lamp_q(clr_lamp), .pre_level_listen_q(pre_t),
        .after_level_listen_q(post_t), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task give_verdict;
        if (num_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Hang guard, well above the expected run length
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic check_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    function automatic logic [7:0] lfsr_next();
        lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        return lfsr_q;
    endfunction

    // Shown outputs: hidden behind inputs only under input priority
    function automatic int lit_m();
        return (mode_m[1] && in_m != 0) ? 0 : mem_m;
    endfunction

    task automatic check_lamp();
        int l;
        l = lit_m();
        check_reg("lamps", {13'h0, in_m[7:0], l[5:0], in_m != 0, l != 0, (in_m | l) != 0, !mode_m[2], mode_m[2]},
            {13'h0, in_led, out_led, in_act, out_act, clr_lamp, pre_t, post_t});
    endtask

    // Index 0-7 input class, 8-13 output class, 14 and 15 clear
    task automatic model_press(int k);
        int b;
        b = (k < 8) ? (in_m >> k) & 1 : (lit_m() >> (k - 8)) & 1;
        if (k >= 14) begin
            if (mode_m[1] && in_m != 0) in_m = 0;
            else {in_m, mem_m} = 0;
        end else if (mode_m[0]) begin
            {in_m, mem_m} = 0;
            if (!b && k < 8) in_m = 1 << k;
            if (!b && k >= 8) mem_m = 1 << (k - 8);
        end else if (k < 8) in_m ^= 1 << k;
        else mem_m ^= 1 << (k - 8);
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        bit aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        @(posedge ref_clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        while (!(aw_ok && w_ok)) begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'b1) aw_ok = 1;
            if (s_axi_wready === 1'b1) w_ok = 1;
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end
        // Late bready on purpose, so the slave must hold its answer
        while (s_axi_bvalid !== 1'b1) @(posedge ref_clk);
        s_axi_bready <= 1'b1;
        @(posedge ref_clk);
        check_reg("bresp", er, s_axi_bresp);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge ref_clk);
        s_axi_rready <= 1'b1;
        @(posedge ref_clk);
        d = s_axi_rdata;
        check_reg("rresp", er, s_axi_rresp);
        s_axi_rready <= 1'b0;
    endtask

    task automatic check_regs();
        axi_read(`SSC_OFS_IN_SOLO, `SSC_RESP_OKAY, rd);
        check_reg("in_solo", in_m, rd);
        axi_read(`SSC_OFS_OUT_MEM, `SSC_RESP_OKAY, rd);
        check_reg("out_mem", mem_m, rd);
        axi_read(`SSC_OFS_OUT_LIT, `SSC_RESP_OKAY, rd);
        check_reg("out_lit", lit_m(), rd);
    endtask

    // Clear code 15 goes over the bus, the rest through the panel
    task automatic press(int k, bit chat);
        if (k == 15) axi_write(`SSC_OFS_CMD, 32'h1, 4'h1, `SSC_RESP_OKAY);
        @(posedge ref_clk);
        go <= (k != 15);
        idx <= k[3:0];
        chatter <= chat;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (40) @(posedge ref_clk);
        if (!chat) model_press(k);
        check_lamp();
    endtask

    initial begin
        {go, chatter, idx, sys_rst, lfsr_q} = {7'h1, 8'h8};
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {num_errors, total_checks, cycles, in_m, mem_m, mode_m} = 0;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check_lamp();
        axi_read(`SSC_OFS_CTRL, `SSC_RESP_OKAY, rd);
        check_reg("ctrl", 32'h0, rd);
        axi_read(8'h20, `SSC_RESP_DECERR, rd);
        check_reg("unmapped", 32'h0, rd);
        axi_write(8'h20, 32'h7, 4'h1, `SSC_RESP_DECERR);
        axi_write(`SSC_OFS_CTRL, 32'h7, 4'h0, `SSC_RESP_OKAY);
        axi_read(`SSC_OFS_CTRL, `SSC_RESP_OKAY, rd);
        check_reg("ctrl", 32'h0, rd);
        press(3, 1);
        // Every mode combination, random presses from the panel and bus
        for (m = 0; m < 8; m++) begin
            axi_write(`SSC_OFS_CTRL, m, 4'h1, `SSC_RESP_OKAY);
            mode_m = m;
            axi_read(`SSC_OFS_CTRL, `SSC_RESP_OKAY, rd);
            check_reg("ctrl", m, rd);
            check_lamp();
            for (n = 0; n < 16; n++) begin
                press(lfsr_next() % 16, 0);
                check_regs();
            end
        end
        axi_read(`SSC_OFS_STATUS, `SSC_RESP_OKAY, rd);
        check_reg("status", {28'h0, mode_m[2], (in_m | lit_m()) != 0, lit_m() != 0, in_m != 0}, rd);
        give_verdict();
    end
endmodule

bind ssc_solo_ctrl ssc_solo_chk #(.N_IN(N_IN), .N_OUT(N_OUT)) u_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .in_solo_led_q(in_solo_led_q), .out_solo_led_q(out_solo_led_q),
    .in_active_led_q(in_active_led_q), .out_active_led_q(out_active_led_q), .clear_lamp_q(clear_lamp_q),
    .pre_level_listen_q(pre_level_listen_q), .after_level_listen_q(after_level_listen_q),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
